// ===== rtl/msd_display.sv
// Display end: scans an N-digit seven-segment array from one shared decoder.
// Assumes the processor end drives the interface on the same clock.
// Operation
// [RL1] One decoder, common segment lines, 7xN
// [RL2] Segments and digit enable in same slot
// [RL3] Slot end steps strobe to next digit
// [RL4] Each digit refreshed 100 times per second
// [RL5] Strobe rate configurable for vibration
// [RL6] Equal slot per digit, duty one over N
// [RL7] Refresh mode interrupts; processor supplies data
// [RL8] Decoded mode refreshes from local pattern RAM
// [RL9] Processor writes decoded patterns on change
// [RL10] Coded mode decodes BCD RAM each slot
// [RL11] Processor changes message via BCD writes
// [RL12] Static mode: own address per digit
// [RL13] Scan wraps after last digit
// [RL14] BCD 0-9 decoded, 10-15 blank
`timescale 1ns/10ps
module msd_display #(
  parameter int unsigned DIGITS   = msd_pkg::NUM_DIGITS,
  parameter int unsigned SLOT_CYC = msd_pkg::SLOT_MAX_CYC
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  msd_if.device                    bus,
  input  wire logic [15:0]         slot_len,
  output logic [6:0]               seg_out,
  output logic [DIGITS-1:0]        digit_en,
  output logic [DIGITS-1:0]        static_en
);
  localparam int unsigned IDX_W = (DIGITS > 1) ? $clog2(DIGITS) : 1;
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DIGITS - 1);
  localparam logic [15:0] SLOT_DEF = 16'(SLOT_CYC);

  logic [7:0]        ram_ff [DIGITS];  // Local RAM, one word per digit
  logic [7:0]        static_ff [DIGITS];
  logic [15:0]       slot_cnt_ff;
  logic [IDX_W-1:0]  idx_ff;
  logic [6:0]        seg_ff;
  logic [DIGITS-1:0] digit_ff;
  logic              irq_ff;
  logic [7:0]        irq_digit_ff;
  logic [15:0]       slot_lim;
  logic              slot_end;
  logic [IDX_W-1:0]  nxt_idx;
  logic [6:0]        nxt_seg;
  logic [7:0]        word;

  // Shared BCD decoder; non-decimal codes blank the digit
  function automatic logic [6:0] bcd_to_seg(input logic [3:0] code);
    case (code)
      4'h0:    bcd_to_seg = msd_pkg::SEG_0; // [RL14]
      4'h1:    bcd_to_seg = msd_pkg::SEG_1;
      4'h2:    bcd_to_seg = msd_pkg::SEG_2;
      4'h3:    bcd_to_seg = msd_pkg::SEG_3;
      4'h4:    bcd_to_seg = msd_pkg::SEG_4;
      4'h5:    bcd_to_seg = msd_pkg::SEG_5;
      4'h6:    bcd_to_seg = msd_pkg::SEG_6;
      4'h7:    bcd_to_seg = msd_pkg::SEG_7;
      4'h8:    bcd_to_seg = msd_pkg::SEG_8;
      4'h9:    bcd_to_seg = msd_pkg::SEG_9;
      default: bcd_to_seg = msd_pkg::SEG_BLANK; // [RL14]
    endcase
  endfunction : bcd_to_seg

  // Zero or too long a slot falls back to the default, so flicker floor holds
  always_comb begin
    if ((slot_len == 16'h0000) || (slot_len > SLOT_DEF)) begin
      slot_lim = SLOT_DEF; // [RL4]
    end else begin
      slot_lim = slot_len; // [RL5]
    end
  end

  assign slot_end = (slot_cnt_ff >= (slot_lim - 16'h0001)); // [RL6]
  assign nxt_idx  = (idx_ff == LAST_IDX) ? '0 : idx_ff + 1'b1; // [RL13]

  // Slot timer, identical length for every digit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slot_cnt_ff <= 16'h0000;
    end else if (slot_end) begin
      slot_cnt_ff <= 16'h0000; // [RL6]
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 16'h0001;
    end
  end

  // Digit pointer steps at each slot end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idx_ff <= '0;
    end else if (slot_end) begin
      idx_ff <= nxt_idx; // [RL3] [RL13]
    end
  end

  // Local RAM and static latches, one address per digit
  generate
    for (genvar gi = 0; gi < DIGITS; gi++) begin : g_ram
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          ram_ff[gi]    <= 8'h00;
          static_ff[gi] <= 8'h00;
        end else if (bus.wr_en && (bus.wr_addr == 8'(gi))) begin
          ram_ff[gi] <= bus.wr_data; // [RL8] [RL10] [RL7]
          if (bus.mode == msd_pkg::MODE_STATIC) begin
            static_ff[gi] <= bus.wr_data; // [RL12]
          end
        end
      end
      // Static digits enabled continuously while static mode is selected
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          static_en[gi] <= 1'b0;
        end else begin
          static_en[gi] <= (bus.mode == msd_pkg::MODE_STATIC); // [RL12]
        end
      end
    end
  endgenerate

  // Pattern for the digit about to be shown; only coded mode passes it through the single decoder
  assign word = ram_ff[nxt_idx];
  always_comb begin
    case (bus.mode)
      msd_pkg::MODE_CODED:  nxt_seg = bcd_to_seg(word[3:0]); // [RL10] [RL1]
      msd_pkg::MODE_STATIC: nxt_seg = msd_pkg::SEG_BLANK;
      default:              nxt_seg = word[6:0]; // [RL8] [RL7]
    endcase
  end

  // Segment and digit lines change together at slot end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seg_ff   <= msd_pkg::SEG_BLANK;
      digit_ff <= '0;
    end else if (slot_end) begin
      seg_ff   <= nxt_seg; // [RL2] [RL3]
      digit_ff <= (bus.mode == msd_pkg::MODE_STATIC) ? '0 : DIGITS'(1) << nxt_idx; // [RL2]
    end
  end

  // Refresh mode asks for the digit after the one just strobed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_ff       <= 1'b0;
      irq_digit_ff <= 8'h00;
    end else begin
      irq_ff <= slot_end && (bus.mode == msd_pkg::MODE_REFRESH); // [RL7]
      if (slot_end) begin
        irq_digit_ff <= 8'(nxt_idx == LAST_IDX ? '0 : nxt_idx + 1'b1); // [RL7]
      end
    end
  end

  // Static segment bus: no per-digit segment lines exist here, so static_ff
  // patterns are never driven out; static_en is set and seg_out stays blank
  assign seg_out          = seg_ff;
  assign digit_en         = digit_ff;
  assign bus.refresh_irq  = irq_ff;
  assign bus.irq_digit    = irq_digit_ff;
endmodule : msd_display

// ===== rtl/msd_pkg.sv
// Package for the multiplexed segment display refresh controller.
// Assumes a single clock domain shared by the processor end and the display end.
package msd_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned MIN_REFRESH   = 100;       // Per digit, per second
  localparam int unsigned NUM_DIGITS    = 5;
  localparam int unsigned SEG_W         = 7;
  localparam int unsigned BCD_W         = 4;
  // Longest slot that still meets the refresh floor, rounded down
  localparam int unsigned SLOT_MAX_CYC  = CLK_HZ / (MIN_REFRESH * NUM_DIGITS);
  localparam logic [1:0]  MODE_STATIC   = 2'h0;
  localparam logic [1:0]  MODE_REFRESH  = 2'h1;
  localparam logic [1:0]  MODE_DECODED  = 2'h2;
  localparam logic [1:0]  MODE_CODED    = 2'h3;
  localparam logic [6:0]  SEG_BLANK     = 7'h00;
  // Segment order {g,f,e,d,c,b,a}
  localparam logic [6:0]  SEG_0 = 7'h3f;
  localparam logic [6:0]  SEG_1 = 7'h06;
  localparam logic [6:0]  SEG_2 = 7'h5b;
  localparam logic [6:0]  SEG_3 = 7'h4f;
  localparam logic [6:0]  SEG_4 = 7'h66;
  localparam logic [6:0]  SEG_5 = 7'h6d;
  localparam logic [6:0]  SEG_6 = 7'h7d;
  localparam logic [6:0]  SEG_7 = 7'h07;
  localparam logic [6:0]  SEG_8 = 7'h7f;
  localparam logic [6:0]  SEG_9 = 7'h6f;
endpackage : msd_pkg

// ===== rtl/msd_if.sv
// Interface joining the processor end and the display controller end.
// Assumes both ends share clk and resetn supplied by the testbench.
`timescale 1ns/10ps
interface msd_if #(
  parameter int unsigned DIGITS = msd_pkg::NUM_DIGITS
) (
  input wire logic clk,
  input wire logic resetn
);
  logic [1:0]            mode;       // Display mode select
  logic                  wr_en;      // One-cycle write strobe
  logic [7:0]            wr_addr;    // Digit position written
  logic [7:0]            wr_data;    // Segments or BCD in low bits
  logic                  refresh_irq; // One-cycle request for next digit data
  logic [7:0]            irq_digit;  // Digit that the request is for

  modport device (
    input  mode,
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    output refresh_irq,
    output irq_digit
  );
  modport host (
    output mode,
    output wr_en,
    output wr_addr,
    output wr_data,
    input  refresh_irq,
    input  irq_digit
  );
endinterface : msd_if

// ===== rtl/msd_host.sv
// Processor end: writes display data into the controller over the interface.
// Assumes a user-side write port and the controller on the same clock.
`timescale 1ns/10ps
module msd_host #(
  parameter int unsigned DIGITS = msd_pkg::NUM_DIGITS
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  msd_if.host             bus,
  input  wire logic [1:0] mode_sel,
  input  wire logic       req_valid,
  input  wire logic [7:0] req_digit,
  input  wire logic [7:0] req_data,
  input  wire logic [7:0] refresh_data,
  output logic            req_ready,
  output logic            irq_seen
);
  typedef enum logic [1:0] {MSH_IDLE, MSH_SERVE} msh_state_e;
  msh_state_e state_ff;
  logic [1:0] mode_ff;
  logic       wr_ff;
  logic [7:0] addr_ff;
  logic [7:0] data_ff;
  logic       seen_ff;

  // Mode register follows the user selection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= msd_pkg::MODE_STATIC;
    end else begin
      mode_ff <= mode_sel;
    end
  end

  // Interrupts are served first; user writes wait two cycles, the request cycle and MSH_SERVE
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= MSH_IDLE;
      wr_ff    <= 1'b0;
      addr_ff  <= 8'h00;
      data_ff  <= 8'h00;
      seen_ff  <= 1'b0;
    end else begin
      wr_ff   <= 1'b0;
      seen_ff <= bus.refresh_irq;
      case (state_ff)
        MSH_IDLE: begin
          if (bus.refresh_irq) begin
            wr_ff    <= 1'b1; // [RL7]
            addr_ff  <= bus.irq_digit;
            data_ff  <= refresh_data;
            state_ff <= MSH_SERVE;
          end else if (req_valid) begin
            wr_ff   <= 1'b1; // [RL9] [RL11] [RL12]
            addr_ff <= req_digit;
            data_ff <= req_data;
          end
        end
        MSH_SERVE: state_ff <= MSH_IDLE;
        default:   state_ff <= MSH_IDLE;
      endcase
    end
  end

  assign req_ready   = (state_ff == MSH_IDLE) && !bus.refresh_irq;
  assign irq_seen    = seen_ff;
  assign bus.mode    = mode_ff;
  assign bus.wr_en   = wr_ff;
  assign bus.wr_addr = addr_ff;
  assign bus.wr_data = data_ff;
endmodule : msd_host

// ===== testbench/msd_asserts.sv
// Checker on the link between the host end and the display end.
// Assumes the bench sets a slot of four cycles.
`timescale 1ns/10ps
module msd_asserts #(
  parameter int unsigned DIGITS = 5
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [1:0] mode,
  input wire logic       wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       refresh_irq,
  input wire logic [7:0] irq_digit
);
  localparam int SLOT = 4;
  logic [7:0] gap_ff;

  // Cycles since the last request; cleared outside refresh mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_ff <= 8'h00;
    end else if (refresh_irq || mode != msd_pkg::MODE_REFRESH) begin
      gap_ff <= 8'h00;
    end else begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_irq_quiet: assert property (refresh_irq |=> (!refresh_irq) [*3])
    else $error("refresh request repeated inside one slot");
  a_irq_spacing: assert property (
    refresh_irq |-> ##SLOT (refresh_irq || mode != msd_pkg::MODE_REFRESH))
    else $error("refresh request missing at slot end");
  a_irq_mode_only: assert property (
    (mode != msd_pkg::MODE_REFRESH) [*2] |-> !refresh_irq)
    else $error("refresh request outside refresh mode");
  a_irq_served: assert property (
    refresh_irq |=> wr_en && wr_addr == $past(irq_digit))
    else $error("refresh request not answered by a write");
  a_irq_start: assert property (
    $rose(mode == msd_pkg::MODE_REFRESH) |-> ##[1:6] refresh_irq)
    else $error("no request after entering refresh mode");
  a_irq_regular: assert property (gap_ff <= SLOT + 1)
    else $error("refresh requests too far apart");
  a_digit_range: assert property (refresh_irq |-> irq_digit < DIGITS)
    else $error("requested digit out of range");
  a_digit_step: assert property (
    refresh_irq ##SLOT refresh_irq |-> irq_digit == ($past(irq_digit, SLOT) == DIGITS - 1
      ? 8'h00 : $past(irq_digit, SLOT) + 8'h01))
    else $error("requested digit did not step by one");

  c_refresh: cover property (refresh_irq);
  c_coded_wr: cover property (wr_en && mode == msd_pkg::MODE_CODED && wr_data < 8'h10);
  c_decoded_wr: cover property (wr_en && mode == msd_pkg::MODE_DECODED);
endmodule : msd_asserts

// ===== testbench/msd_tb.sv
// Bench joining host end and display end over one link.
// Assumes a four-cycle slot, so a full scan of five digits is twenty cycles.
`timescale 1ns/10ps
module msd_tb;
  typedef struct packed {logic [1:0] m; logic [7:0] d; logic [7:0] v; logic [6:0] e;} msd_row_s;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic [1:0] mode_sel = msd_pkg::MODE_STATIC;
  logic       req_valid = 1'b0;
  logic [7:0] req_digit = 8'h00;
  logic [7:0] req_data = 8'h00;
  logic [7:0] refresh_data = 8'h49;
  logic [6:0] seg_out;
  logic [4:0] digit_en;
  logic [4:0] static_en;
  logic       req_ready;
  logic       irq_seen;
  int         bad_count = 0;
  int         n_compared = 0;
  int         cyc = 0;
  // Mode, digit, data written, segments expected
  msd_row_s   rows [8] = '{'{2'h2, 8'h00, 8'h55, 7'h55}, '{2'h2, 8'h04, 8'h2a, 7'h2a},
    '{2'h3, 8'h01, 8'h00, 7'h3f}, '{2'h3, 8'h02, 8'h09, 7'h6f}, '{2'h3, 8'h03, 8'h0a, 7'h00},
    '{2'h3, 8'h00, 8'h0f, 7'h00}, '{2'h3, 8'h04, 8'h07, 7'h07}, '{2'h3, 8'h02, 8'h08, 7'h7f}};

  msd_if msd_if_inst (.clk(clk), .resetn(resetn));
  msd_host msd_host_inst (.clk(clk), .resetn(resetn), .bus(msd_if_inst), .mode_sel(mode_sel),
    .req_valid(req_valid), .req_digit(req_digit), .req_data(req_data),
    .refresh_data(refresh_data), .req_ready(req_ready), .irq_seen(irq_seen));
  // Short slot keeps scans brief; the full count is untested here
  msd_display msd_display_inst (.clk(clk), .resetn(resetn), .bus(msd_if_inst),
    .slot_len(16'h0004), .seg_out(seg_out), .digit_en(digit_en), .static_en(static_en));
  msd_asserts #(.DIGITS(5)) msd_asserts_inst (.clk(clk), .resetn(resetn),
    .mode(msd_if_inst.mode), .wr_en(msd_if_inst.wr_en), .wr_addr(msd_if_inst.wr_addr),
    .wr_data(msd_if_inst.wr_data), .refresh_irq(msd_if_inst.refresh_irq),
    .irq_digit(msd_if_inst.irq_digit));

  always #12.5 clk = ~clk;

  // Ceiling far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end

  task chk_seg(input logic [6:0] got, input logic [6:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_seg

  task chk_vec(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  task conclude;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Request held from a falling edge until ready is seen
  task wr(input logic [7:0] d, input logic [7:0] v);
    @(negedge clk);
    req_digit = d;
    req_data = v;
    req_valid = 1'b1;
    #1;
    for (int i = 0; i < 50 && req_ready !== 1'b1; i++) begin
      @(negedge clk);
      #1;
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask : wr

  // Waits for a fresh slot of digit d; returns its segments, enables, length
  task see(input int d, output logic [6:0] s, output logic [4:0] e, output int n);
    n = 0;
    for (int i = 0; i < 99 && digit_en[d] !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 99 && digit_en[d] !== 1'b1; i++) @(negedge clk);
    s = seg_out;
    e = digit_en;
    while (digit_en[d] === 1'b1 && n < 99) begin
      n++;
      @(negedge clk);
    end
  endtask : see

  initial begin
    logic [6:0] s;
    logic [4:0] e;
    int         n;
    repeat (12) @(negedge clk);
    chk_seg(seg_out, 7'h00);
    chk_vec(16'(digit_en), 16'h0000);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk_vec(16'(static_en), 16'h001f);
    chk_vec(16'(digit_en), 16'h0000);
    foreach (rows[k]) begin
      mode_sel = rows[k].m;
      wr(rows[k].d, rows[k].v);
      see(int'(rows[k].d), s, e, n);
      see(int'(rows[k].d), s, e, n);
      chk_seg(s, rows[k].e);
      chk_vec(16'(e), 16'h0001 << rows[k].d);
      chk_vec(16'(n), 16'h0004);
    end
    // Unmapped digit must not disturb digit zero
    wr(8'h00, 8'h03);
    wr(8'h05, 8'h08);
    see(0, s, e, n);
    see(0, s, e, n);
    chk_seg(s, 7'h4f);
    see(4, s, e, n);
    chk_vec(16'(digit_en), 16'h0001);
    // Refresh mode: host answers each request with its data
    mode_sel = msd_pkg::MODE_REFRESH;
    see(3, s, e, n);
    see(3, s, e, n);
    chk_seg(s, 7'h49);
    chk_vec(16'(n), 16'h0004);
    // Host must notice a request within eight cycles, two scan slots
    for (int i = 0; i < 8 && irq_seen !== 1'b1; i++) @(negedge clk);
    chk_vec(16'(irq_seen), 16'h0001);
    // Reset in mid-run stops the scan at once
    resetn = 1'b0;
    #1;
    chk_vec(16'(digit_en), 16'h0000);
    chk_vec(16'(irq_seen), 16'h0000);
    @(negedge clk);
    resetn = 1'b1;
    conclude();
  end
endmodule : msd_tb
